/* File: hw/wrc_top.sv */
// Watchdog timer and reset-cause controller.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wrc_top
   import wrc_pkg::*;
(
   // Clock and power-on reset.
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // Register port.
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output var  logic [7:0] rdata_o,
   // Asynchronous pins.
   input  wire logic       slow_osc_i,
   input  wire logic       lowvolt_i,
   input  wire logic       option_always_i,
   // Core events, one-cycle pulses.
   input  wire logic       clear_instr_i,
   input  wire logic       sleep_entry_i,
   input  wire logic       wake_i,
   // Reset outputs and state.
   output var  logic       sys_reset_o,
   output var  logic       pc_sp_reset_o,
   output var  logic       powered_down_o,
   output var  logic [7:0] port_data_o,
   output var  logic [7:0] port_dir_o
);

   // ------------------------------------------------------------
   // Input synchronisation.
   // ------------------------------------------------------------

   logic [2:0] in_sync;     // Synchronised pins.
   logic       slow_prev;   // Previous slow clock level.

   wrc_sync2 #(.W(3)) u_sync
   (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .d_i    ({slow_osc_i, lowvolt_i, option_always_i}),
      .q_o    (in_sync)
   );

   wire slow_s    = in_sync[2];
   wire low_s     = in_sync[1];
   wire always_s  = in_sync[0];
   wire slow_tick = slow_s && !slow_prev;

   // ------------------------------------------------------------
   // State.
   // ------------------------------------------------------------

   logic [7:0]           wdt_ctrl;   // Key and time-out select.
   logic [7:0]           thresh;     // Threshold key register.
   logic [4:0]           key_q;      // Key as seen by the slow ticks.
   logic [7:0]           thr_q;      // Threshold as seen by the ticks.
   logic                 keep;       // Idle system clock keep bit.
   logic                 lv_flag;    // Low-voltage reset cause.
   logic                 thr_flag;   // Bad threshold cause.
   logic                 key_flag;   // Bad watchdog key cause.
   logic                 to_flag;    // Watchdog expiry.
   logic                 pdf;        // Power-down entered.
   logic [WDT_CNT_W-1:0] wdt_cnt;    // Watchdog counter.
   logic [7:0]           low_cnt;    // Low-supply duration.
   logic                 lv_pend;    // Genuine low supply caught.
   logic                 fire_wk;    // Bad key reset request.
   logic                 fire_thr;   // Bad threshold reset request.
   logic                 fire_lv;    // Low supply reset request.

   // ------------------------------------------------------------
   // Decoding.
   // ------------------------------------------------------------

   wire wr_wdt  = wr_i && addr_i == ADDR_WDT_CTRL;
   wire wr_sys  = wr_i && addr_i == ADDR_SYS_CTRL;
   wire wr_thr  = wr_i && addr_i == ADDR_THRESH;
   wire wr_pd   = wr_i && addr_i == ADDR_PORT_DATA;
   wire wr_pr   = wr_i && addr_i == ADDR_PORT_DIR;

   // Either valid key runs the watchdog under the always-on option;
   // under program control only the run key does.
   wire key_ok  = key_q == KEY_RUN || key_q == KEY_STOP;
   wire wdt_run = key_q == KEY_RUN || (always_s && key_q == KEY_STOP);

   // Only four threshold patterns are legal.
   wire thr_ok  = thr_q == THRESH_POR || thr_q == THRESH_K1 ||
                  thr_q == THRESH_K2  || thr_q == THRESH_K3;

   // Select code picks 2^8 up to 2^18 ticks in ascending order.
   wire [WDT_CNT_W-1:0] wdt_limit =
      WDT_CNT_W'((1 << DIV_LOG2[wdt_ctrl[2:0]]) - 1);

   // Overflow on the last tick of the period.
   wire wdt_ovf = slow_tick && wdt_run && wdt_cnt == wdt_limit;

   // The supply must stay low past the minimum; power-down disarms it.
   wire low_long = low_s && !pdf && low_cnt == 8'(LV_MIN_CYC);

   // Any full reset request lands on sys_reset_o one cycle later.
   wire next_full = (wdt_ovf && !powered_down_o) || fire_wk ||
                    fire_thr || fire_lv;

   // Read selection; unmapped offsets read zero.
   wire [7:0] sys_rd  = {keep, 4'h0, lv_flag, thr_flag, key_flag};
   wire [7:0] stat_rd = {6'h0, to_flag, pdf};
   wire [7:0] rd_mux  =
      addr_i == ADDR_WDT_CTRL  ? wdt_ctrl  :
      addr_i == ADDR_SYS_CTRL  ? sys_rd    :
      addr_i == ADDR_THRESH    ? thresh    :
      addr_i == ADDR_STATUS    ? stat_rd   :
      addr_i == ADDR_PORT_DATA ? port_data_o :
      addr_i == ADDR_PORT_DIR  ? port_dir_o  : 8'h00;

   // ------------------------------------------------------------
   // Delayed fault resets.
   // ------------------------------------------------------------

   // Each fault reset waits two to three slow cycles.
   wrc_fault_delay u_wk
   (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .clr_i  (sys_reset_o),
      .tick_i (slow_tick),
      .trig_i (!key_ok),
      .fire_o (fire_wk)
   );

   wrc_fault_delay u_thr
   (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .clr_i  (sys_reset_o),
      .tick_i (slow_tick),
      .trig_i (!thr_ok),
      .fire_o (fire_thr)
   );

   wrc_fault_delay u_lv
   (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .clr_i  (sys_reset_o),
      .tick_i (slow_tick),
      .trig_i (lv_pend),
      .fire_o (fire_lv)
   );

   // ------------------------------------------------------------
   // Slow-domain sampling.
   // ------------------------------------------------------------

   // Keys are sampled only on slow ticks, so a glitch between ticks
   // is never seen as a fault.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         slow_prev <= 1'b0;
      end
      else
      begin
         slow_prev <= slow_s;
      end
      // A full reset drops the stale samples too; otherwise the old bad key
      // would be caught again at the next tick and fire a second reset.
      if (rst_i || sys_reset_o)
      begin
         key_q <= KEY_RUN;
         thr_q <= THRESH_POR;
      end
      else if (slow_tick)
      begin
         key_q <= wdt_ctrl[7:KEY_LSB];
         thr_q <= thresh;
      end
   end

   // ------------------------------------------------------------
   // Reset outputs.
   // ------------------------------------------------------------

   // Power-on holds the full reset high, which clears the PC.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         sys_reset_o   <= 1'b1;
         pc_sp_reset_o <= 1'b0;
      end
      else
      begin
         sys_reset_o   <= next_full;
         pc_sp_reset_o <= wdt_ovf && powered_down_o;
      end
   end

   // ------------------------------------------------------------
   // Watchdog counter.
   // ------------------------------------------------------------

   // Reset, the clear instruction, sleep entry and an overflow clear it.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || sys_reset_o || clear_instr_i || sleep_entry_i || wdt_ovf)
      begin
         wdt_cnt <= '0;
      end
      else if (slow_tick && wdt_run)
      begin
         wdt_cnt <= wdt_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Low supply filter.
   // ------------------------------------------------------------

   // The count restarts on every return to good supply, so short
   // dips never accumulate into a reset.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || sys_reset_o || !low_s || pdf)
      begin
         low_cnt <= 8'h00;
      end
      else if (low_cnt != 8'(LV_MIN_CYC))
      begin
         low_cnt <= low_cnt + 8'h01;
      end
      if (rst_i || sys_reset_o)
      begin
         lv_pend <= 1'b0;
      end
      else if (low_long)
      begin
         lv_pend <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Writable registers.
   // ------------------------------------------------------------

   // Any full reset restores the watchdog key and the ports.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || sys_reset_o)
      begin
         wdt_ctrl    <= WDT_CTRL_POR;
         port_data_o <= PORT_POR;
         port_dir_o  <= PORT_POR;
      end
      else
      begin
         if (wr_wdt)
         begin
            wdt_ctrl <= wdata_i;
         end
         if (wr_pd)
         begin
            port_data_o <= wdata_i;
         end
         if (wr_pr)
         begin
            port_dir_o <= wdata_i;
         end
      end
   end

   // The threshold survives a genuine low-supply reset and is only
   // restored at power-on or when its own key was bad.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || fire_thr)
      begin
         thresh <= THRESH_POR;
      end
      else if (wr_thr && !sys_reset_o)
      begin
         thresh <= wdata_i;
      end
   end

   // ------------------------------------------------------------
   // Cause flags.
   // ------------------------------------------------------------

   // A set on the same edge as a clearing write wins; a written one
   // leaves a flag as it was.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         keep     <= 1'b0;
         lv_flag  <= 1'b0;
         thr_flag <= 1'b0;
         key_flag <= 1'b0;
      end
      else
      begin
         if (wr_sys)
         begin
            keep <= wdata_i[KEEP_BIT];
         end
         lv_flag  <= fire_lv  || (lv_flag  && !(wr_sys && !wdata_i[LV_FLAG_BIT]));
         thr_flag <= fire_thr || (thr_flag && !(wr_sys && !wdata_i[THR_FLAG_BIT]));
         key_flag <= fire_wk  || (key_flag && !(wr_sys && !wdata_i[KEY_FLAG_BIT]));
      end
   end

   // ------------------------------------------------------------
   // Status and power-down.
   // ------------------------------------------------------------

   // Expiry is set by any overflow; sleep entry and the clear
   // instruction clear it, but a same-edge overflow wins.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         to_flag        <= 1'b0;
         pdf            <= 1'b0;
         powered_down_o <= 1'b0;
         rdata_o        <= 8'h00;
      end
      else
      begin
         to_flag <= wdt_ovf || (to_flag && !clear_instr_i && !sleep_entry_i);
         pdf     <= sleep_entry_i || (pdf && !clear_instr_i);
         // Overflow in sleep wakes the core with PC and SP cleared.
         powered_down_o <= sleep_entry_i ||
                           (powered_down_o && !wake_i && !wdt_ovf && !sys_reset_o);
         rdata_o <= rd_i ? rd_mux : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   property p_run_ovf;
      wdt_ovf && !powered_down_o |=> sys_reset_o && to_flag;
   endproperty
   a_run_ovf: assert property (p_run_ovf)
      else $error("Run-mode overflow did not reset");

   property p_sleep_ovf;
      wdt_ovf && powered_down_o |=> pc_sp_reset_o && to_flag && !powered_down_o;
   endproperty
   a_sleep_ovf: assert property (p_sleep_ovf)
      else $error("Sleep overflow did not reset PC and SP");

   property p_stop_key;
      !always_s && key_q == KEY_STOP && $stable(key_q) |-> !wdt_ovf;
   endproperty
   a_stop_key: assert property (p_stop_key)
      else $error("Stopped watchdog overflowed");

   property p_wk_fault;
      fire_wk |=> sys_reset_o && key_flag ##1 wdt_ctrl == WDT_CTRL_POR;
   endproperty
   a_wk_fault: assert property (p_wk_fault)
      else $error("Bad key fault not handled");

   property p_thr_fault;
      fire_thr |=> sys_reset_o && thr_flag && thresh == THRESH_POR;
   endproperty
   a_thr_fault: assert property (p_thr_fault)
      else $error("Bad threshold not restored");

   property p_clear;
      clear_instr_i |=> wdt_cnt == '0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("Clear instruction left counter");

   property p_lv_hold;
      lv_flag && !(wr_sys && !wdata_i[LV_FLAG_BIT]) |=> lv_flag;
   endproperty
   a_lv_hold: assert property (p_lv_hold)
      else $error("Low-voltage flag lost");

   property p_rsvd;
      rd_i && addr_i == ADDR_SYS_CTRL |=> rdata_o[6:3] == 4'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("Reserved control bits not zero");

   property p_por;
      $fell(rst_i) |-> port_dir_o == PORT_POR && wdt_ctrl[7:KEY_LSB] == KEY_RUN;
   endproperty
   a_por: assert property (p_por)
      else $error("Power-on values wrong");

   property p_pd_lv;
      pdf |=> low_cnt == 8'h00;
   endproperty
   a_pd_lv: assert property (p_pd_lv)
      else $error("Low supply armed in power-down");

   c_run_ovf:   cover property (wdt_ovf && !powered_down_o);
   c_sleep_ovf: cover property (wdt_ovf && powered_down_o);
   c_thr:       cover property (fire_thr);
   c_lv:        cover property (fire_lv);
endmodule
`default_nettype wire

/* File: hw/wrc_pkg.sv */
// Constants for the watchdog and reset-cause controller.
// Functional notes
// - Watchdog overflow resets the device
// - Always-on option: both keys run watchdog
// - Always-on option: bad key resets later
// - Program option: stop key halts, run key runs
// - Program option: bad key resets later
// - Power-on loads the run key
// - Run-mode overflow resets, sets expiry flag
// - Sleep overflow sets flag, resets PC/SP
// - Only reset, clear, sleep clear counter; overflow also clears it here
// - Divide ratios span 2^8 to 2^18
// - Power-on clears the program counter
// - Power-on sets port registers all ones
// - Long low supply resets, sets flag
// - Short low supply dips are ignored
// - Threshold field accepts only four keys
// - Bad threshold resets and restores default
// - Low supply reset delayed, threshold kept
// - Bad threshold flag cleared by zero write
// - Low-voltage flag cleared by zero write
// - Low supply reset off in power-down
// - Control bits six to three read zero
// - Select code orders ratios small to large
// - Bad watchdog key sets key fault flag
package wrc_pkg;
   // ------------------------------------------------------------
   // Register offsets.
   // ------------------------------------------------------------
   localparam logic [2:0] ADDR_WDT_CTRL  = 3'h0;
   localparam logic [2:0] ADDR_SYS_CTRL  = 3'h1;
   localparam logic [2:0] ADDR_THRESH    = 3'h2;
   localparam logic [2:0] ADDR_STATUS    = 3'h3;
   localparam logic [2:0] ADDR_PORT_DATA = 3'h4;
   localparam logic [2:0] ADDR_PORT_DIR  = 3'h5;
   // ------------------------------------------------------------
   // Field positions and reset values.
   // ------------------------------------------------------------
   localparam int          KEY_LSB       = 3;
   localparam int          KEEP_BIT      = 7;
   localparam int          LV_FLAG_BIT   = 2;
   localparam int          THR_FLAG_BIT  = 1;
   localparam int          KEY_FLAG_BIT  = 0;
   localparam int          TO_BIT        = 1;
   localparam int          PDF_BIT       = 0;
   localparam logic [7:0]  WDT_CTRL_POR  = 8'h53;
   localparam logic [4:0]  KEY_RUN       = 5'h0a;
   localparam logic [4:0]  KEY_STOP      = 5'h15;
   localparam logic [7:0]  THRESH_POR    = 8'h55;
   localparam logic [7:0]  THRESH_K1     = 8'h33;
   localparam logic [7:0]  THRESH_K2     = 8'h99;
   localparam logic [7:0]  THRESH_K3     = 8'haa;
   localparam logic [7:0]  PORT_POR      = 8'hff;
   // ------------------------------------------------------------
   // Timing.
   // ------------------------------------------------------------
   localparam int          WDT_CNT_W     = 18;
   localparam int          DIV_LOG2 [8]  = '{8, 10, 12, 14, 15, 16, 17, 18};
   localparam int          FAULT_TICKS   = 2;
   localparam int          MCLK_MHZ      = 125;
   localparam int          LV_MIN_NS     = 1000;
   localparam int          LV_MIN_CYC    = (LV_MIN_NS * MCLK_MHZ + 999) / 1000;
endpackage

/* File: hw/wrc_sync2.sv */
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module wrc_sync2
#(
   parameter int W = 1
)
(
   // Clock and reset.
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);
   logic [W-1:0] meta;   // First stage, read only by the second.

   // The first stage may go metastable; only q_o is used downstream.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         q_o  <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: hw/wrc_fault_delay.sv */
// Delays a fault into a reset by a fixed count of slow ticks.
`timescale 1ns/1ps
`default_nettype none
module wrc_fault_delay
   import wrc_pkg::*;
(
   // Clock and reset.
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // Clear on a full device reset.
   input  wire logic clr_i,
   // Slow oscillator tick and fault level.
   input  wire logic tick_i,
   input  wire logic trig_i,
   // One-cycle reset request.
   output var  logic fire_o
);
   logic [1:0] cnt;   // Ticks seen since the fault was caught.

   // A fault caught at one tick fires at the second tick after it, so the
   // reset follows the fault by two to three slow cycles.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i || clr_i)
      begin
         cnt    <= 2'h0;
         fire_o <= 1'b0;
      end
      else
      begin
         fire_o <= tick_i && (cnt == 2'(FAULT_TICKS));
         if (tick_i && (trig_i || cnt != 2'h0) && cnt != 2'(FAULT_TICKS))
         begin
            cnt <= cnt + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/wrc_top_tb.sv */
// Self-checking testbench for the watchdog and reset-cause controller.
`timescale 1ns/1ps
`default_nettype none
module wrc_top_tb
   import wrc_pkg::*;
;
   // ------------------------------------------------------------
   // Stimulus, observed outputs and bookkeeping.
   // ------------------------------------------------------------
   logic       mclk_i          = 1'b0;
   logic       rst_i           = 1'b1;
   logic [2:0] addr_i          = 3'h0;
   logic [7:0] wdata_i         = 8'h00;
   logic       wr_i            = 1'b0;
   logic       rd_i            = 1'b0;
   logic       slow_osc_i      = 1'b0;
   logic       lowvolt_i       = 1'b0;
   logic       option_always_i = 1'b1;
   logic       clear_instr_i   = 1'b0;
   logic       sleep_entry_i   = 1'b0;
   logic       wake_i          = 1'b0;
   logic [7:0] rdata_o;
   logic       sys_reset_o;
   logic       pc_sp_reset_o;
   logic       powered_down_o;
   logic [7:0] port_data_o;
   logic [7:0] port_dir_o;
   logic [2:0] div_cnt         = 3'h0; // Slow oscillator divider, period 8 cycles.
   logic [7:0] v;                      // Scratch value for random data.
   logic [4:0] key;                    // Scratch watchdog key.
   int         miscompares     = 0;
   int         total_checks    = 0;
   int         n_sys;                  // Full reset pulses seen in a window.
   int         n_pcsp;                 // PC/SP reset pulses seen in a window.
   int         first_sys;              // Cycle of the first full reset pulse.

   wrc_top wrc_top_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .slow_osc_i(slow_osc_i), .lowvolt_i(lowvolt_i), .option_always_i(option_always_i),
      .clear_instr_i(clear_instr_i), .sleep_entry_i(sleep_entry_i), .wake_i(wake_i),
      .sys_reset_o(sys_reset_o), .pc_sp_reset_o(pc_sp_reset_o), .powered_down_o(powered_down_o),
      .port_data_o(port_data_o), .port_dir_o(port_dir_o));

   // ------------------------------------------------------------
   // Clocks.
   // ------------------------------------------------------------
   // Main clock, 8 ns period.
   initial
   begin
      forever #4 mclk_i = ~mclk_i;
   end

   // The slow oscillator is far slower in silicon; a short period keeps the run brief.
   always @(posedge mclk_i)
   begin
      div_cnt    <= div_cnt + 3'h1;
      slow_osc_i <= div_cnt[2];
   end

   // ------------------------------------------------------------
   // Compare, bus and event tasks.
   // ------------------------------------------------------------
   // Compares an eight-bit design value.
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Compares a bench count against an inclusive range.
   task automatic chkr(input int got, input int lo, input int hi);
      total_checks++;
      if (got < lo || got > hi)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   // One-cycle write; the strobe drops one edge later.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask

   // One-cycle read; data stand only in the following cycle.
   task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1;
      chk8(rdata_o, exp);
   endtask

   // Core event pulse: 0 clear, 1 sleep entry, 2 wake.
   task automatic ev(input int k);
      @(posedge mclk_i);
      clear_instr_i <= (k == 0);
      sleep_entry_i <= (k == 1);
      wake_i        <= (k == 2);
      @(posedge mclk_i);
      clear_instr_i <= 1'b0;
      sleep_entry_i <= 1'b0;
      wake_i        <= 1'b0;
   endtask

   // Watches both reset outputs for a fixed number of cycles.
   task automatic run(input int n);
      n_sys     = 0;
      n_pcsp    = 0;
      first_sys = -1;
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk_i);
         #1;
         if (sys_reset_o === 1'b1)
         begin
            if (first_sys < 0)
               first_sys = i;
            n_sys++;
         end
         if (pc_sp_reset_o === 1'b1)
            n_pcsp++;
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic final_report;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // A hang is cut short here and counted as a mismatch.
   initial
   begin
      #400000;
      miscompares++;
      final_report();
   end

   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(42));
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      // Power-on values, and an unmapped offset reads zero.
      chk8(port_data_o, PORT_POR);
      chk8(port_dir_o, PORT_POR);
      rdchk(ADDR_WDT_CTRL, WDT_CTRL_POR);
      rdchk(ADDR_THRESH, THRESH_POR);
      rdchk(ADDR_STATUS, 8'h00);
      rdchk(3'h6, 8'h00);
      // Ones written to the cause flags and unused bits must not stick.
      wr(ADDR_SYS_CTRL, 8'hff);
      rdchk(ADDR_SYS_CTRL, 8'h80);
      wr(ADDR_SYS_CTRL, 8'h00);
      // Random port data, read back.
      repeat (4)
      begin
         v = 8'($urandom);
         wr(ADDR_PORT_DATA, v);
         rdchk(ADDR_PORT_DATA, v);
         wr(ADDR_PORT_DIR, ~v);
         rdchk(ADDR_PORT_DIR, ~v);
      end
      // Every defined threshold key is accepted without a reset.
      foreach (key[i])
      begin
         v = (i == 0) ? THRESH_K1 : (i == 1) ? THRESH_K2 : (i == 2) ? THRESH_K3 : THRESH_POR;
         wr(ADDR_THRESH, v);
         run(40);
         chkr(n_sys, 0, 0);
         rdchk(ADDR_THRESH, v);
      end
      // An undefined threshold resets after a few slow ticks and restores the default.
      do v = 8'($urandom); while (v inside {THRESH_POR, THRESH_K1, THRESH_K2, THRESH_K3});
      wr(ADDR_THRESH, v);
      run(60);
      chkr(n_sys, 1, 1);
      chkr(first_sys, 8, 40);
      rdchk(ADDR_THRESH, THRESH_POR);
      chk8(port_dir_o, PORT_POR);
      rdchk(ADDR_SYS_CTRL, 8'h02);
      wr(ADDR_SYS_CTRL, 8'h00);
      rdchk(ADDR_SYS_CTRL, 8'h00);
      // A corrupt watchdog key resets under both options.
      for (int opt = 0; opt < 2; opt++)
      begin
         @(posedge mclk_i);
         option_always_i <= opt[0];
         do key = 5'($urandom); while (key == KEY_RUN || key == KEY_STOP);
         run(4);
         wr(ADDR_WDT_CTRL, {key, 3'h3});
         run(60);
         chkr(n_sys, 1, 1);
         chkr(first_sys, 8, 40);
         rdchk(ADDR_SYS_CTRL, 8'h01);
         rdchk(ADDR_WDT_CTRL, WDT_CTRL_POR);
         wr(ADDR_SYS_CTRL, 8'h00);
      end
      // Overflow at the shortest ratio, per option and key; only one case stays quiet.
      for (int i = 0; i < 4; i++)
      begin
         @(posedge mclk_i);
         option_always_i <= (i < 2);
         key = (i == 0 || i == 3) ? KEY_RUN : KEY_STOP;
         wr(ADDR_PORT_DATA, 8'h3c);
         wr(ADDR_WDT_CTRL, {key, 3'h0});
         ev(0);
         run(2100);
         chkr(n_sys, (i == 2) ? 0 : 1, (i == 2) ? 0 : 1);
         if (i != 2)
         begin
            chkr(first_sys, 2030, 2075);
            chk8(port_data_o, PORT_POR);
            rdchk(ADDR_STATUS, 8'h02);
            ev(0);
         end
      end
      // Regular clears keep the counter from overflowing.
      wr(ADDR_WDT_CTRL, {KEY_RUN, 3'h0});
      repeat (6)
      begin
         run(1600);
         ev(0);
         chkr(n_sys, 0, 0);
      end
      // Overflow while asleep resets only the program counter and stack.
      ev(1);
      #1;
      chk8({7'h00, powered_down_o}, 8'h01);
      rdchk(ADDR_STATUS, 8'h01);
      run(2100);
      chkr(n_pcsp, 1, 1);
      chkr(n_sys, 0, 0);
      rdchk(ADDR_STATUS, 8'h03);
      rdchk(ADDR_WDT_CTRL, {KEY_RUN, 3'h0});
      wr(ADDR_WDT_CTRL, WDT_CTRL_POR);
      ev(2);
      ev(0);
      // A short supply dip is ignored, a long one resets and keeps the threshold.
      wr(ADDR_THRESH, THRESH_K2);
      @(posedge mclk_i);
      lowvolt_i <= 1'b1;
      run(100);
      @(posedge mclk_i);
      lowvolt_i <= 1'b0;
      run(60);
      chkr(n_sys, 0, 0);
      @(posedge mclk_i);
      lowvolt_i <= 1'b1;
      run(200);
      chkr(n_sys, 1, 20);
      chkr(first_sys, 125, 170);
      @(posedge mclk_i);
      lowvolt_i <= 1'b0;
      run(40);
      rdchk(ADDR_THRESH, THRESH_K2);
      rdchk(ADDR_SYS_CTRL, 8'h04);
      wr(ADDR_SYS_CTRL, 8'h00);
      rdchk(ADDR_SYS_CTRL, 8'h00);
      // In power-down the low-supply reset is disarmed.
      wr(ADDR_WDT_CTRL, {KEY_STOP, 3'h0});
      ev(1);
      @(posedge mclk_i);
      lowvolt_i <= 1'b1;
      run(250);
      chkr(n_sys, 0, 0);
      @(posedge mclk_i);
      lowvolt_i <= 1'b0;
      ev(2);
      ev(0);
      final_report();
   end
endmodule
`default_nettype wire
